// file: bench/vsm_decoder_tb.sv
module vsm_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vsm_pkg::*;
   localparam int SD = 20;
   localparam int PM = 10;
   logic                clock, arst_n, cpuStop_n, deeperRequest, twoChRequest;
   logic                railsGood, coreOut, pwmPhase1, pwmPhase2, diodeEmulation;
   logic                powerGoodOut, powerGoodOe_n;
   logic [1:0]          chanWiring;
   logic [VID_W-1:0]    vidCode;
   logic [DATA_W-1:0]   rdata, st;
   logic [MV_W-1:0]     dacCommandVoltage, regulationTarget;
   vsm_pins_t           pins;
   vsm_levels_t         levels;
   vsm_bus_t            bus;
   vsm_mode_t           mode;
   int                  errTotal, nTests;

   vsm_system_model i_vsm_system_model (.cpuStop_n(cpuStop_n),
      .deeperRequest(deeperRequest), .chanWiring(chanWiring),
      .twoChRequest(twoChRequest), .vidCode(vidCode), .railsGood(railsGood),
      .coreOut(coreOut), .powerGoodOe_n(powerGoodOe_n), .pins(pins));
   vsm_decoder #(.START_DELAY(SD), .PG_MASK(PM)) i_vsm_decoder (.clock(clock),
      .arst_n(arst_n), .pins(pins), .levels(levels), .bus(bus), .rdata(rdata),
      .pwmPhase1(pwmPhase1), .pwmPhase2(pwmPhase2), .diodeEmulation(diodeEmulation),
      .dacCommandVoltage(dacCommandVoltage), .regulationTarget(regulationTarget),
      .mode(mode), .powerGoodOut(powerGoodOut), .powerGoodOe_n(powerGoodOe_n));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic busWr(logic [3:0] a, logic [31:0] d);
      @(posedge clock);
      bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask
   task automatic busRd(logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      bus.addr <= a; bus.rd <= 1'b1;
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic giveVerdict;
      $display("tests %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic tBoot;
      cyc(6);
      chk("boot target", regulationTarget, 11'h4B0 - 11'h010);
      chk("boot mode", mode, MODE_ACTIVE);
      busRd(4'h8, st);
      chk("wait pg", st[1:0], 2'h1);
      railsGood <= 1'b1;
      cyc(6);
      busRd(4'h8, st);
      chk("delay state", st[1:0], 2'h2);
      chk("held boot", regulationTarget, 11'h4B0 - 11'h010);
      cyc(SD + 4);
      chk("run deep mode", mode, MODE_DEEP);
      $display("test boot done");
   endtask
   task automatic tVid;
      int codes [4] = '{5, 32, 63, 0};
      logic [10:0] prev, e;
      prev = 11'h6AC;
      cpuStop_n <= 1'b1;
      foreach (codes[i]) begin
         e = 11'h6AC - 11'(codes[i]) * 11'h010;
         @(posedge clock);
         vidCode <= 6'(codes[i]);
         cyc(1);
         chk("dac before sync", dacCommandVoltage, prev);
         cyc(5);
         chk("dac", dacCommandVoltage, e);
         chk("active target", regulationTarget, e - 11'h010);
         prev = e;
      end
      $display("test vid done");
   endtask
   task automatic tModes;
      logic dsn, drs;
      vsm_mode_t em;
      logic [10:0] et;
      for (int w = 1; w <= 2; w++) begin
         for (int r = 0; r < 4; r++) begin
            dsn = r[1];
            drs = r[0];
            em = drs ? MODE_DEEPER : (dsn ? MODE_ACTIVE : MODE_DEEP);
            et = (drs ? 11'h320 : (dsn ? 11'h6AC : 11'h3E8)) - 11'h010;
            cpuStop_n <= dsn; deeperRequest <= drs; chanWiring <= 2'(w);
            cyc(5);
            chk("mode", mode, em);
            chk("sleep target", regulationTarget, et);
            chk("diode", diodeEmulation, em == MODE_DEEP);
            busRd(4'h8, st);
            chk("status", st[5:2], {(w == 1) ? dsn : ~drs, em == MODE_DEEP, em});
         end
      end
      chanWiring <= 2'h0; cpuStop_n <= 1'b1; deeperRequest <= 1'b0;
      $display("test modes done");
   endtask
   task automatic tPwm;
      int gap, hi2;
      busWr(4'h0, 32'h0000000A);
      busRd(4'h0, st);
      chk("period floor", st[9:0], 10'h07D);
      busWr(4'h0, 32'h000003E8);
      busRd(4'h0, st);
      chk("period ceiling", st[9:0], 10'h1F4);
      busWr(4'h0, 32'h000000C8);
      busWr(4'h4, 32'h00000032);
      repeat (300) begin cyc(1); if (pwmPhase1 === 1'b0) break; end
      repeat (300) begin cyc(1); if (pwmPhase1 === 1'b1) break; end
      gap = 0;
      repeat (300) begin cyc(1); gap++; if (pwmPhase2 === 1'b1) break; end
      chk("phase gap", gap, 100);
      twoChRequest <= 1'b0;
      cyc(4);
      hi2 = 0;
      repeat (210) begin cyc(1); if (pwmPhase2 !== 1'b0) hi2++; end
      chk("single channel", hi2, 0);
      twoChRequest <= 1'b1;
      $display("test pwm done");
   endtask
   task automatic tPg;
      coreOut <= 1'b1;
      cyc(6);
      chk("fault pulls", powerGoodOe_n, 1'b0);
      chk("pin level", powerGoodOut, 1'b0);
      vidCode <= 6'h01;
      cyc(5);
      chk("masked", powerGoodOe_n, 1'b1);
      cyc(PM - 5);
      chk("still masked", powerGoodOe_n, 1'b1);
      cyc(8);
      chk("mask over", powerGoodOe_n, 1'b0);
      coreOut <= 1'b0;
      busWr(4'hC, 32'h0000005A);
      busRd(4'hC, st);
      chk("unmapped read", st, 32'h0);
      $display("test power good done");
   endtask

   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      errTotal++;
      giveVerdict();
   end
   initial begin
      errTotal = 0; nTests = 0; arst_n = 1'b0; bus = '0;
      cpuStop_n = 1'b0; deeperRequest = 1'b0; twoChRequest = 1'b1; chanWiring = 2'h0;
      vidCode = 6'h00; railsGood = 1'b0; coreOut = 1'b0;
      levels = {11'h4B0, 11'h3E8, 11'h320, 11'h010};
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      tBoot();
      tVid();
      tModes();
      tPwm();
      tPg();
      giveVerdict();
   end
endmodule // vsm_decoder_tb

// file: bench/vsm_system_model.sv
// ----------------------------------------
// processor and power-management side
// ----------------------------------------
module vsm_system_model (
   // requests from the bench
   input  wire logic                     cpuStop_n,
   input  wire logic                     deeperRequest,
   input  wire logic [1:0]               chanWiring,
   input  wire logic                     twoChRequest,
   input  wire logic [vsm_pkg::VID_W-1:0] vidCode,
   input  wire logic                     railsGood,
   input  wire logic                     coreOut,
   // open-drain power-good, pulled up
   input  wire logic                     powerGoodOe_n,
   // pins toward the device
   output vsm_pkg::vsm_pins_t            pins
);
   timeunit 1ns;
   timeprecision 1ps;
   import vsm_pkg::*;
   always_comb begin
      pins.deepSleepEnable_n = cpuStop_n;
      pins.deeperSleepEnable = deeperRequest;
      pins.voltageId         = vidCode;
      pins.outOfRange        = coreOut;
      // wire is low if either the rails or the device pull it
      pins.powerGood         = railsGood & powerGoodOe_n;
      case (chanWiring)
         2'h1:    pins.channelCountSelect = cpuStop_n;
         2'h2:    pins.channelCountSelect = ~deeperRequest;
         default: pins.channelCountSelect = twoChRequest;
      endcase
   end
endmodule // vsm_system_model

// file: rtl/vsm_decoder.sv
// Contract
// - in two-channel operation phase PWMs run half a period apart
// - channel select high runs both channels, low runs only channel one
// - switching period is held inside the 250 kHz to 1 MHz range
// - six-bit code decodes to 1708 mV minus 16 mV per step
// - power-good fault pulldown is masked while the code changes
// - sleep inputs are read only after start-up; high/low gives Active
// - Active follows the code and regulates to it minus droop
// - both enables low gives Deep Sleep at the deep-sleep setpoint
// - Deep Sleep turns on diode emulation
// - deeper enable high, deep enable low gives Deeper Sleep setpoint
// - deeper enable high always selects Deeper Sleep
// - start-up regulates to boot setpoint until power-good goes high
// - fixed delay after power-good before moving to the code voltage
//
// The register addresses and the plain strobed port were chosen for this implementation.
module vsm_decoder
   import vsm_pkg::*;
#(
   parameter int START_DELAY = START_DELAY_CYC,
   parameter int PG_MASK     = PG_MASK_CYC
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   // asynchronous control pins
   input  wire vsm_pkg::vsm_pins_t    pins,
   // setpoint words, same clock
   input  wire vsm_pkg::vsm_levels_t  levels,
   // register port
   input  wire vsm_pkg::vsm_bus_t     bus,
   output logic [vsm_pkg::DATA_W-1:0] rdata,
   // power stage
   output logic                       pwmPhase1,
   output logic                       pwmPhase2,
   output logic                       diodeEmulation,
   output logic [vsm_pkg::MV_W-1:0]   dacCommandVoltage,
   output logic [vsm_pkg::MV_W-1:0]   regulationTarget,
   output vsm_pkg::vsm_mode_t         mode,
   // power-good pin, open drain
   output logic                       powerGoodOut,
   output logic                       powerGoodOe_n
);
   import vsm_pkg::*;

   typedef struct packed {
      vsm_pins_t         sync1;
      vsm_pins_t         sync2;
      logic [VID_W-1:0]  lastVid;
      vsm_start_t        start;
      logic [11:0]       delayCnt;
      logic [11:0]       maskCnt;
      logic [CNT_W-1:0]  period;
      logic [CNT_W-1:0]  duty;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  cnt2;
      logic              pwm1;
      logic              pwm2;
      logic              diode;
      vsm_mode_t         mode;
      logic [MV_W-1:0]   dac;
      logic [MV_W-1:0]   target;
      logic              pgOe_n;
      logic [DATA_W-1:0] rdata;
   } vsm_state_t;

   vsm_state_t state;
   vsm_state_t next_state;

   function automatic logic [MV_W-1:0] vidToMv(input logic [VID_W-1:0] code);
      vidToMv = VID_TOP_MV - MV_W'(code) * VID_STEP_MV;
   endfunction

   function automatic logic [MV_W-1:0] lessDroop(input logic [MV_W-1:0] sp,
                                                  input logic [MV_W-1:0] dr);
      lessDroop = (sp > dr) ? sp - dr : '0;
   endfunction

   function automatic logic [CNT_W-1:0] clampPeriod(input logic [CNT_W-1:0] p);
      if (p < CNT_W'(PERIOD_MIN_CYC))
         clampPeriod = CNT_W'(PERIOD_MIN_CYC);
      else if (p > CNT_W'(PERIOD_MAX_CYC))
         clampPeriod = CNT_W'(PERIOD_MAX_CYC);
      else
         clampPeriod = p;
   endfunction

   // wraps at once when a write has shrunk the period below the count
   function automatic logic [CNT_W-1:0] wrapInc(input logic [CNT_W-1:0] c,
                                                input logic [CNT_W-1:0] p);
      wrapInc = (c >= p - 10'h001) ? '0 : c + 10'h001;
   endfunction

   logic twoCh;
   logic running;
   logic [MV_W-1:0] setpoint;
   assign twoCh   = state.sync2.channelCountSelect;
   assign running = (state.start == ST_RUN);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      // second stage only ever reads the first
      next_state.sync1 = pins;
      next_state.sync2 = state.sync1;
      next_state.lastVid = state.sync2.voltageId;
      next_state.dac = vidToMv(state.sync2.voltageId);

      // start-up sequencing
      unique case (state.start)
         ST_BOOT: begin
            next_state.start = ST_WAIT_PG;
         end
         ST_WAIT_PG: begin
            if (state.sync2.powerGood) begin
               next_state.start    = ST_DELAY;
               next_state.delayCnt = 12'(START_DELAY - 1);
            end
         end
         ST_DELAY: begin
            if (state.delayCnt == '0)
               next_state.start = ST_RUN;
            else
               next_state.delayCnt = state.delayCnt - 12'h001;
         end
         ST_RUN: begin
            next_state.start = ST_RUN;
         end
      endcase

      // mode decode, deeper enable dominates
      if (running) begin
         if (state.sync2.deeperSleepEnable)
            next_state.mode = MODE_DEEPER;
         else if (!state.sync2.deepSleepEnable_n)
            next_state.mode = MODE_DEEP;
         else
            next_state.mode = MODE_ACTIVE;
      end
      next_state.diode = running && (next_state.mode == MODE_DEEP);

      if (!running)
         setpoint = levels.bootSetpoint;
      else begin
         unique case (next_state.mode)
            MODE_ACTIVE: setpoint = state.dac;
            MODE_DEEP:   setpoint = levels.deepSleepSetpoint;
            default:     setpoint = levels.deeperSleepSetpoint;
         endcase
      end
      next_state.target = lessDroop(setpoint, levels.droop);

      // mask window restarts on every code change
      if (state.lastVid != state.sync2.voltageId)
         next_state.maskCnt = 12'(PG_MASK);
      else if (state.maskCnt != '0)
         next_state.maskCnt = state.maskCnt - 12'h001;
      // the pin is an input until start-up is over
      next_state.pgOe_n = !(running && state.sync2.outOfRange && next_state.maskCnt == '0 &&
                            state.maskCnt == '0);

      // interleaved phase counters
      next_state.cnt  = wrapInc(state.cnt, state.period);
      next_state.cnt2 = wrapInc(state.cnt2, state.period);
      // reload on every wrap, one forced by a shortened period too
      if (next_state.cnt == '0)
         next_state.cnt2 = state.period >> 1;
      next_state.pwm1 = running && (next_state.cnt < state.duty);
      next_state.pwm2 = running && twoCh && (next_state.cnt2 < state.duty);

      // register port
      next_state.rdata = '0;
      if (bus.wr) begin
         if (bus.addr == REG_PERIOD)
            next_state.period = clampPeriod(bus.wdata[CNT_W-1:0]);
         if (bus.addr == REG_DUTY)
            next_state.duty = bus.wdata[CNT_W-1:0];
      end
      if (bus.rd) begin
         unique case (bus.addr)
            REG_PERIOD: next_state.rdata = DATA_W'(state.period);
            REG_DUTY:   next_state.rdata = DATA_W'(state.duty);
            REG_STATUS: next_state.rdata = DATA_W'({state.dac, state.maskCnt != '0,
                                                    state.pgOe_n, twoCh, state.diode,
                                                    state.mode, state.start});
            default:    next_state.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state        <= '0;
         state.start  <= ST_BOOT;
         state.mode   <= MODE_ACTIVE;
         state.period <= PERIOD_RST;
         state.duty   <= DUTY_RST;
         state.pgOe_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign rdata             = state.rdata;
   assign pwmPhase1         = state.pwm1;
   assign pwmPhase2         = state.pwm2;
   assign diodeEmulation    = state.diode;
   assign dacCommandVoltage = state.dac;
   assign regulationTarget  = state.target;
   assign mode              = state.mode;
   assign powerGoodOut      = 1'b0;
   assign powerGoodOe_n     = state.pgOe_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_interleave;
      @(posedge clock) disable iff (!arst_n)
      // the reload used the period from before the wrap edge
      (state.cnt == '0) && $past(state.cnt) != '0 |-> state.cnt2 == ($past(state.period) >> 1);
   endproperty
   a_interleave: assert property (p_interleave) else $error("phases not half apart");

   property p_single;
      @(posedge clock) disable iff (!arst_n)
      !twoCh |=> !pwmPhase2;
   endproperty
   a_single: assert property (p_single) else $error("phase two runs in single mode");

   property p_range;
      @(posedge clock) disable iff (!arst_n)
      state.period >= CNT_W'(PERIOD_MIN_CYC) && state.period <= CNT_W'(PERIOD_MAX_CYC);
   endproperty
   a_range: assert property (p_range) else $error("period out of range");

   property p_vid;
      @(posedge clock) disable iff (!arst_n)
      // sampled reset keeps the release edge, with its reset values, out
      arst_n && $stable(state.sync2.voltageId) |=> dacCommandVoltage ==
         VID_TOP_MV - MV_W'($past(state.sync2.voltageId)) * VID_STEP_MV;
   endproperty
   a_vid: assert property (p_vid) else $error("wrong command voltage");

   property p_mask;
      @(posedge clock) disable iff (!arst_n)
      running && $changed(state.sync2.voltageId) |=> powerGoodOe_n [*8];
   endproperty
   a_mask: assert property (p_mask) else $error("power-good pulled during code change");

   property p_notyet;
      @(posedge clock) disable iff (!arst_n)
      !running |=> mode == $past(mode) && !diodeEmulation;
   endproperty
   a_notyet: assert property (p_notyet) else $error("mode moved before start-up");

   property p_active;
      @(posedge clock) disable iff (!arst_n)
      running && $past(running) && state.sync2.deepSleepEnable_n &&
         !state.sync2.deeperSleepEnable |=> mode == MODE_ACTIVE;
   endproperty
   a_active: assert property (p_active) else $error("active mode not taken");

   property p_deep;
      @(posedge clock) disable iff (!arst_n)
      mode == MODE_DEEP && running |-> diodeEmulation;
   endproperty
   a_deep: assert property (p_deep) else $error("no diode emulation in deep sleep");

   property p_deeper;
      @(posedge clock) disable iff (!arst_n)
      running && state.sync2.deeperSleepEnable |=> mode == MODE_DEEPER && !diodeEmulation;
   endproperty
   a_deeper: assert property (p_deeper) else $error("deeper sleep not taken");

   property p_boot;
      @(posedge clock) disable iff (!arst_n)
      // same guard against the release edge
      arst_n && !running && !$past(running) |=> regulationTarget ==
         lessDroop($past(levels.bootSetpoint), $past(levels.droop));
   endproperty
   a_boot: assert property (p_boot) else $error("boot setpoint not used");

   property p_delay;
      @(posedge clock) disable iff (!arst_n)
      state.start == ST_WAIT_PG && state.sync2.powerGood |=> (state.start == ST_DELAY) [*8];
   endproperty
   a_delay: assert property (p_delay) else $error("no delay after power-good");

   c_deep:   cover property (@(posedge clock) disable iff (!arst_n) mode == MODE_DEEP);
   c_deeper: cover property (@(posedge clock) disable iff (!arst_n)
                             $past(mode) == MODE_DEEP && mode == MODE_DEEPER);
   c_two:    cover property (@(posedge clock) disable iff (!arst_n) pwmPhase1 && !pwmPhase2);
   c_fault:  cover property (@(posedge clock) disable iff (!arst_n) !powerGoodOe_n);
   c_single: cover property (@(posedge clock) disable iff (!arst_n) running && !twoCh && pwmPhase1);
endmodule // vsm_decoder

// file: rtl/vsm_pkg.sv
package vsm_pkg;
   // ----------------------------------------
   // widths and encodings
   // ----------------------------------------
   localparam int MV_W   = 11;
   localparam int VID_W  = 6;
   localparam int CNT_W  = 10;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   localparam logic [MV_W-1:0] VID_TOP_MV  = 11'h6AC;  // 1708 mV at code zero
   localparam logic [MV_W-1:0] VID_STEP_MV = 11'h010;  // 16 mV per code

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_KHZ         = 125000;
   localparam int CLK_PERIOD_NS   = 8;
   localparam int FREQ_MIN_KHZ    = 250;
   localparam int FREQ_MAX_KHZ    = 1000;
   localparam int START_DELAY_NS  = 10000;
   localparam int PG_MASK_NS      = 10000;
   localparam int PERIOD_MAX_CYC  = CLK_KHZ / FREQ_MIN_KHZ;
   localparam int PERIOD_MIN_CYC  = (CLK_KHZ + FREQ_MAX_KHZ - 1) / FREQ_MAX_KHZ;
   localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PG_MASK_CYC     = (PG_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h0;
   localparam logic [ADDR_W-1:0] REG_DUTY   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
   localparam logic [CNT_W-1:0]  PERIOD_RST = CNT_W'(PERIOD_MAX_CYC);
   localparam logic [CNT_W-1:0]  DUTY_RST   = 10'h000;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_ACTIVE, MODE_DEEP, MODE_DEEPER} vsm_mode_t;
   typedef enum logic [1:0] {ST_BOOT, ST_WAIT_PG, ST_DELAY, ST_RUN} vsm_start_t;

   typedef struct packed {
      logic              deepSleepEnable_n;
      logic              deeperSleepEnable;
      logic              channelCountSelect;
      logic [VID_W-1:0]  voltageId;
      logic              powerGood;
      logic              outOfRange;
   } vsm_pins_t;

   typedef struct packed {
      logic [MV_W-1:0] bootSetpoint;
      logic [MV_W-1:0] deepSleepSetpoint;
      logic [MV_W-1:0] deeperSleepSetpoint;
      logic [MV_W-1:0] droop;
   } vsm_levels_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } vsm_bus_t;
endpackage
